// ===== bench/bhl_host.sv
// register bus master model issuing one-word holding register accesses
`timescale 1ns/100ps
module bhl_host (
    input wire logic clk,
    output logic [15:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    initial {addr, wdata, wr, rd} = '0;
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask : put
    // read data held until next read
    task automatic get(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask : get
endmodule : bhl_host

// ===== bench/tb.sv
// self-checking bench of the battery log and alarm register bank
`timescale 1ns/100ps
`include "bhl_regs.svh"
module tb;
    import bhl_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr, wdata;
    logic wr, rd, rvalid, relay, mst, cst, prs;
    bhl_word_t rdata, v, ro [10];
    bhl_word_t bv = 16'h1234, cl = 16'h001F, fc = '0, hc = '0;
    logic cob = 1'b0, lte = 1'b0, nm = 1'b0, hve = 1'b0, mr = 1'b0, md = 1'b0, ab = 1'b0;
    int n_fail = 0, n_checks = 0, cyc = 0;
    localparam logic [15:0] RA [10] = '{`BHL_SENSE_VOLT, `BHL_REF_RES, `BHL_DISCH_USED, `BHL_EFF_CAP,
        `BHL_AUTO_HEALTH, `BHL_TIME_EMPTY, `BHL_PERIODIC_PCT, `BHL_AUTO_RES, `BHL_MAN_RES, `BHL_MAN_HEALTH};
    // 100 MHz clock
    always #5 clk = ~clk;
    initial for (int i = 0; i < 10; i++) ro[i] = 16'h0100 + 16'(i);
    bhl_host i_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
    // short day so a sample is logged within the test
    bhl_top #(.CYCLES_PER_DAY(64'd20), .LOG_DEPTH(250)) i_dut (.clk(clk), .resetn(resetn),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .sense_voltage(ro[0]), .reference_resistance(ro[1]), .discharge_used(ro[2]),
        .effective_capacity(ro[3]), .auto_health(ro[4]), .time_to_empty(ro[5]), .periodic_percent(ro[6]),
        .measured_internal_resistance(ro[7]), .manual_resistance(ro[8]), .manual_health(ro[9]),
        .battery_voltage(bv), .charge_level(cl), .charging_or_backup(cob), .fault_cond(fc),
        .life_test_en(lte), .nominal_mismatch(nm), .health_cond(hc), .high_voltage_event(hve),
        .manual_ready(mr), .manual_done(md), .auto_busy(ab), .alarm_relay(relay),
        .manual_test_start(mst), .cable_test_start(cst), .param_reset(prs));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        i_host.get(a, v);
        chk(v, e);
        chk({15'h0, rvalid}, 16'h0001);
    endtask : rc
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // hang guard, tests need about 260 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 10; i++) rc(RA[i], ro[i]);
        rc(`BHL_LOG_PERIOD, 16'h001E);
        rc(16'h9C00, 16'h0000);
        i_host.put(`BHL_LOG_PERIOD, 16'h0006);
        rc(`BHL_LOG_PERIOD, 16'h001E);
        i_host.put(`BHL_LOG_PERIOD, 16'h016E);
        rc(`BHL_LOG_PERIOD, 16'h001E);
        i_host.put(`BHL_LOG_PERIOD, 16'h0007);
        rc(`BHL_LOG_PERIOD, 16'h0007);
        $display("test registers done");
        {fc, hc, nm, cob, cl, bv} = {16'hFFFF, 16'hFFFF, 2'b11, 16'h001D, 16'h1000};
        rc(`BHL_FAULT_FLAGS, 16'h0387);
        chk({15'h0, relay}, 16'h0001);
        lte = 1'b1;
        rc(`BHL_FAULT_FLAGS, 16'h038F);
        rc(`BHL_HEALTH_FLAGS, 16'h1C81);
        rc(`BHL_ALARM_TWO, 16'h0003);
        rc(`BHL_LOWEST_VOLT, 16'h1000);
        i_host.put(`BHL_LOW_V_THR, 16'h2000);
        rc(`BHL_LOW_V_EVENTS, 16'h0001);
        hve = 1'b1;
        @(negedge clk) hve = 1'b0;
        rc(`BHL_HIGH_V_EVENTS, 16'h0001);
        $display("test alarms done");
        i_host.put(`BHL_MAN_LAUNCH, 16'h0001);
        chk({15'h0, mst}, 16'h0000);
        rc(`BHL_MAN_LAUNCH, 16'h0000);
        mr = 1'b1;
        i_host.put(`BHL_MAN_LAUNCH, 16'h0001);
        chk({15'h0, mst}, 16'h0001);
        rc(`BHL_MAN_LAUNCH, 16'h0001);
        rc(`BHL_TEST_KIND, 16'h0001);
        md = 1'b1;
        @(negedge clk) md = 1'b0;
        rc(`BHL_MAN_LAUNCH, 16'h0000);
        rc(`BHL_TEST_KIND, 16'h0000);
        ab = 1'b1;
        rc(`BHL_TEST_KIND, 16'h0002);
        ab = 1'b0;
        $display("test manual done");
        i_host.put(`BHL_LOG_COUNT, 16'h0000);
        rc(`BHL_LOG_COUNT, 16'h0000);
        i_host.put(`BHL_LOG_CTRL, 16'h001B);
        repeat (150) @(negedge clk);
        rc(`BHL_LOG_BASE, ro[7]);
        rc(`BHL_LOG_BASE + 16'd249, 16'h0000);
        rc(`BHL_LOG_COUNT, 16'h0001);
        i_host.put(`BHL_LOG_CTRL, 16'h0000);
        rc(`BHL_LOG_BASE, 16'h0000);
        i_host.put(`BHL_CABLE_TEST, 16'h0001);
        chk({15'h0, cst}, 16'h0001);
        i_host.put(`BHL_CAP_20H, 16'h0ABC);
        rc(`BHL_CAP_20H, 16'h0ABC);
        i_host.put(`BHL_LOW_SOC_THR, 16'h0050);
        i_host.put(`BHL_PARAM_RESET, 16'h0001);
        chk({15'h0, prs}, 16'h0001);
        rc(`BHL_CAP_20H, 16'h0000);
        rc(`BHL_LOW_SOC_THR, 16'h001E);
        $display("test log and settings done");
        conclude();
    end
endmodule : tb

// ===== hw/bhl_day_timer.sv
// free running day tick generator
`timescale 1ns/100ps
`include "bhl_regs.svh"
module bhl_day_timer #(
    parameter logic [63:0] CYCLES_PER_DAY = `BHL_CYCLES_PER_DAY
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic day_tick
);
    import bhl_pkg::*;
    logic [63:0] cnt_q; // cycles into the current day

    // one pulse per elapsed day
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 64'h0;
            day_tick <= 1'b0;
        end
        else
        begin
            day_tick <= (cnt_q == CYCLES_PER_DAY - 64'h1);
            cnt_q <= (cnt_q == CYCLES_PER_DAY - 64'h1) ? 64'h0 : cnt_q + 64'h1;
        end
    end
endmodule : bhl_day_timer

// ===== hw/bhl_log_if.sv
// link between the register bank and the sample ring store
`timescale 1ns/100ps
interface bhl_log_if;
    logic push; // store one sample
    logic [15:0] push_data; // sample value
    logic clear; // empty the log
    logic [7:0] rd_idx; // 0 is the oldest sample
    logic [15:0] rd_data; // sample at rd_idx
    logic [7:0] count; // samples held
    modport owner (output push, push_data, clear, rd_idx, input rd_data, count);
    modport store (input push, push_data, clear, rd_idx, output rd_data, count);
endinterface : bhl_log_if

// ===== hw/bhl_pkg.sv
// shared types of the battery log and alarm bank
package bhl_pkg;
    // register word
    typedef logic [15:0] bhl_word_t;
    // health test currently running, in register encoding order
    typedef enum logic [1:0] {BHL_TEST_NONE, BHL_TEST_MANUAL, BHL_TEST_AUTO} bhl_test_t;
endpackage : bhl_pkg

// ===== hw/bhl_regs.svh
// register offsets, field positions, reset values and timing counts of the battery log and alarm bank
`ifndef BHL_REGS_SVH
`define BHL_REGS_SVH
`define BHL_SENSE_VOLT 16'h9C44
`define BHL_REF_RES 16'h9C4F
`define BHL_DISCH_USED 16'h9C50
`define BHL_EFF_CAP 16'h9C52
`define BHL_AUTO_HEALTH 16'h9C55
`define BHL_TIME_EMPTY 16'h9C56
`define BHL_PERIODIC_PCT 16'h9C57
`define BHL_AUTO_RES 16'h9C5C
`define BHL_FAULT_FLAGS 16'h9C60
`define BHL_HEALTH_FLAGS 16'h9C61
`define BHL_ALARM_TWO 16'h9C63
`define BHL_CABLE_TEST 16'h9C68
`define BHL_LOW_V_EVENTS 16'h9C74
`define BHL_HIGH_V_EVENTS 16'h9C75
`define BHL_MAX_DOD 16'h9C7D
`define BHL_LOWEST_VOLT 16'h9C7E
`define BHL_AVG_DOD 16'h9C80
`define BHL_PARAM_RESET 16'h9C85
`define BHL_HEALTH_EN 16'h9C9C
`define BHL_LOW_V_THR 16'h9CA1
`define BHL_MAN_LAUNCH 16'h9CA3
`define BHL_MAN_ALLOWED 16'h9CA4
`define BHL_NOM_RES 16'h9CA5
`define BHL_CABLE_RES 16'h9CA6
`define BHL_CAP_20H 16'h9CA9
`define BHL_CAP_10H 16'h9CAA
`define BHL_CAP_5H 16'h9CAC
`define BHL_CAP_2H 16'h9CAD
`define BHL_CAP_1H 16'h9CB0
`define BHL_LOW_SOC_THR 16'h9CB1
`define BHL_MAN_RES 16'h9CB3
`define BHL_MAN_HEALTH 16'h9CB4
`define BHL_TEST_KIND 16'h9CB5
`define BHL_FULL_VOLT 16'h9CB8
`define BHL_LOG_CTRL 16'hA02A
`define BHL_LOG_PERIOD 16'hA02B
`define BHL_LOG_AGE 16'hA02C
`define BHL_LOG_COUNT 16'hA02D
`define BHL_LOG_BASE 16'hA02F
// fault register: reverse, missing, shorted, sulphated, cable, sense, sense reversed
`define BHL_FAULT_MASK 16'h038F
`define BHL_FAULT_SULPH_BIT 3
// health register: periodic low, manual low, rint impossible, soh impossible, rint high
`define BHL_HEALTH_MASK 16'h1C81
`define BHL_NOMV_BIT 0
`define BHL_LOWBATT_BIT 1
`define BHL_LOG_OPEN_CODE 16'h001B
`define BHL_PERIOD_MIN 16'h0007
`define BHL_PERIOD_MAX 16'h016D
`define BHL_PERIOD_RST 16'h001E
`define BHL_LOW_SOC_RST 16'h001E
`define BHL_LOW_V_RST 16'h0000
`define BHL_SETTING_RST 16'h0000
`define BHL_LOG_DEPTH 250
`define BHL_DAY_S 86400
`define BHL_CLK_HZ 100000000
`define BHL_CYCLES_PER_DAY (64'd86400 * 64'd100000000)
`endif

// ===== hw/bhl_sample_log.sv
// circular store of logged resistance samples
`timescale 1ns/100ps
module bhl_sample_log #(
    parameter int DEPTH = 250
) (
    input wire logic clk,
    input wire logic rst_n,
    bhl_log_if.store lg
);
    import bhl_pkg::*;
    // sample array, no reset needed, count guards reads
    logic [15:0] mem [0:DEPTH-1];
    logic [7:0] head_q; // next slot to write
    logic [7:0] count_q; // samples held
    logic [8:0] oldest; // slot of oldest sample
    logic [8:0] phys; // slot addressed by rd_idx
    logic [8:0] head_nx; // write slot after this one

    // fold a sum below twice the depth back into range
    function automatic logic [8:0] wrap(input logic [8:0] a);
        wrap = (a >= 9'(DEPTH)) ? a - 9'(DEPTH) : a;
    endfunction : wrap

    assign oldest = wrap({1'b0, head_q} + 9'(DEPTH) - {1'b0, count_q});
    assign phys = wrap(oldest + {1'b0, lg.rd_idx});
    // a function result cannot be part-selected, so the wrapped pointer gets its own wire
    assign head_nx = wrap({1'b0, head_q} + 9'h001);
    assign lg.rd_data = mem[phys[7:0]];
    assign lg.count = count_q;

    // write pointer and fill level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_q <= 8'h00;
            count_q <= 8'h00;
        end
        else if (lg.clear)
        begin
            head_q <= 8'h00;
            count_q <= 8'h00;
        end
        else if (lg.push)
        begin
            head_q <= head_nx[7:0];
            if (count_q != 8'(DEPTH))
                count_q <= count_q + 8'h01;
        end
    end

    // sample storage
    always_ff @(posedge clk)
    begin
        if (lg.push)
            mem[head_q] <= lg.push_data;
    end

    count_cap_a: assert property (@(posedge clk) disable iff (!rst_n) count_q <= 8'(DEPTH))
        else $error("log count above depth");
endmodule : bhl_sample_log

// ===== hw/bhl_top.sv
// holding register bank: resistance log, battery alarms, health control and charge settings
// Summary of operation
// - log keeps up to 250 resistance samples
// - each period expiry stores newest resistance sample
// - sample period 7 to 365 days, default 30
// - writing 27 to log control opens samples
// - newest sample age and sample count readable
// - samples read as one contiguous register block
// - relay follows any battery fault condition
// - fault bits 0,1,2,3(life test),7
// - low battery flag while charging or backup
// - low flag by voltage or charge threshold
// - bit 0 flags nominal voltage mismatch
// - sense cable fault bits 8 and 9
// - health alarm bits 0,7,10,11,12
// - count low and high voltage events, lowest voltage
// - reset write restores charge and health defaults
// - register shows which health test runs
// - manual launch accepted only while allowed
// - cable test write starts cable measurement
// - holding registers read-only or read-write as listed
// - five capacity settings plus full voltage writable
// - test kind reads 0, 1 or 2
// - launch register clears when manual test ends
`timescale 1ns/100ps
`include "bhl_regs.svh"
module bhl_top #(
    parameter logic [63:0] CYCLES_PER_DAY = `BHL_CYCLES_PER_DAY,
    parameter int LOG_DEPTH = `BHL_LOG_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire bhl_pkg::bhl_word_t reg_wdata,
    output bhl_pkg::bhl_word_t reg_rdata,
    output logic reg_rvalid,
    input wire bhl_pkg::bhl_word_t sense_voltage,
    input wire bhl_pkg::bhl_word_t reference_resistance,
    input wire bhl_pkg::bhl_word_t discharge_used,
    input wire bhl_pkg::bhl_word_t effective_capacity,
    input wire bhl_pkg::bhl_word_t auto_health,
    input wire bhl_pkg::bhl_word_t time_to_empty,
    input wire bhl_pkg::bhl_word_t periodic_percent,
    input wire bhl_pkg::bhl_word_t measured_internal_resistance,
    input wire bhl_pkg::bhl_word_t manual_resistance,
    input wire bhl_pkg::bhl_word_t manual_health,
    input wire bhl_pkg::bhl_word_t battery_voltage,
    input wire bhl_pkg::bhl_word_t charge_level,
    input wire logic charging_or_backup,
    input wire bhl_pkg::bhl_word_t fault_cond,
    input wire logic life_test_en,
    input wire logic nominal_mismatch,
    input wire bhl_pkg::bhl_word_t health_cond,
    input wire logic high_voltage_event,
    input wire logic manual_ready,
    input wire logic manual_done,
    input wire logic auto_busy,
    output logic alarm_relay,
    output logic manual_test_start,
    output logic cable_test_start,
    output logic param_reset
);
    import bhl_pkg::*;

    logic rst_a_q, rst_n; // reset release synchroniser
    logic day_tick; // one pulse per day
    bhl_log_if lg ();

    // release reset through two flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    bhl_day_timer #(.CYCLES_PER_DAY(CYCLES_PER_DAY)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .day_tick(day_tick)
    );

    bhl_sample_log #(.DEPTH(LOG_DEPTH)) u_log (
        .clk(clk),
        .rst_n(rst_n),
        .lg(lg)
    );

    // host write decode
    function automatic logic hit(input logic [15:0] a);
        hit = reg_wr && (reg_addr == a);
    endfunction : hit

    // writable settings and history
    bhl_word_t low_v_thr_q, low_soc_thr_q, nom_res_q, cable_res_q, full_volt_q;
    bhl_word_t cap20_q, cap10_q, cap5_q, cap2_q, cap1_q;
    bhl_word_t max_dod_q, avg_dod_q, health_en_q, reset_reg_q, cable_reg_q;
    bhl_word_t period_q, log_ctrl_q, age_q, launch_q;
    bhl_word_t low_events_q, high_events_q, lowest_volt_q;
    bhl_word_t fault_q, health_q, alarm_two_q;
    logic below_v_q; // previous low voltage state, for edge count
    bhl_test_t kind_q;

    // condition wires
    logic period_ok, period_due, log_open, in_log, launch_ok, fault_any, low_batt, below_v;
    logic [15:0] log_off;
    assign period_ok = (reg_wdata >= `BHL_PERIOD_MIN) && (reg_wdata <= `BHL_PERIOD_MAX);
    assign period_due = day_tick && (age_q + 16'h0001 >= period_q);
    assign log_open = (log_ctrl_q == `BHL_LOG_OPEN_CODE);
    assign log_off = reg_addr - `BHL_LOG_BASE;
    assign in_log = (reg_addr >= `BHL_LOG_BASE) && (log_off < 16'(LOG_DEPTH));
    assign launch_ok = manual_ready && (reg_wdata != 16'h0000) && (launch_q == 16'h0000);
    assign below_v = battery_voltage < low_v_thr_q;
    // only while charging or on backup
    assign low_batt = charging_or_backup && (below_v || (charge_level < low_soc_thr_q));
    // relay on fault, cabling or nominal voltage mismatch
    assign fault_any = (|fault_q) || alarm_two_q[`BHL_NOMV_BIT];

    // ring store hookup
    // sample newest long term resistance at period expiry
    assign lg.push = period_due;
    assign lg.push_data = measured_internal_resistance;
    assign lg.clear = hit(`BHL_LOG_COUNT);
    assign lg.rd_idx = log_off[7:0];

    // settings, all but low_v_thr_q and cable_res_q restored by the battery reset command
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_v_thr_q <= `BHL_LOW_V_RST;
            low_soc_thr_q <= `BHL_LOW_SOC_RST;
            nom_res_q <= `BHL_SETTING_RST;
            cable_res_q <= `BHL_SETTING_RST;
            full_volt_q <= `BHL_SETTING_RST;
            cap20_q <= `BHL_SETTING_RST;
            cap10_q <= `BHL_SETTING_RST;
            cap5_q <= `BHL_SETTING_RST;
            cap2_q <= `BHL_SETTING_RST;
            cap1_q <= `BHL_SETTING_RST;
        end
        // reset command restores charge and health defaults
        else if (hit(`BHL_PARAM_RESET))
        begin
            low_soc_thr_q <= `BHL_LOW_SOC_RST;
            nom_res_q <= `BHL_SETTING_RST;
            full_volt_q <= `BHL_SETTING_RST;
            cap20_q <= `BHL_SETTING_RST;
            cap10_q <= `BHL_SETTING_RST;
            cap5_q <= `BHL_SETTING_RST;
            cap2_q <= `BHL_SETTING_RST;
            cap1_q <= `BHL_SETTING_RST;
        end
        else
        begin
            if (hit(`BHL_LOW_V_THR)) low_v_thr_q <= reg_wdata;
            if (hit(`BHL_LOW_SOC_THR)) low_soc_thr_q <= reg_wdata;
            if (hit(`BHL_NOM_RES)) nom_res_q <= reg_wdata;
            if (hit(`BHL_CABLE_RES)) cable_res_q <= reg_wdata;
            // capacity ratings and full charge voltage
            if (hit(`BHL_FULL_VOLT)) full_volt_q <= reg_wdata;
            if (hit(`BHL_CAP_20H)) cap20_q <= reg_wdata;
            if (hit(`BHL_CAP_10H)) cap10_q <= reg_wdata;
            if (hit(`BHL_CAP_5H)) cap5_q <= reg_wdata;
            if (hit(`BHL_CAP_2H)) cap2_q <= reg_wdata;
            if (hit(`BHL_CAP_1H)) cap1_q <= reg_wdata;
        end
    end

    // plain stored words with no side effect on the block
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            max_dod_q <= `BHL_SETTING_RST;
            avg_dod_q <= `BHL_SETTING_RST;
            health_en_q <= `BHL_SETTING_RST;
            reset_reg_q <= `BHL_SETTING_RST;
            cable_reg_q <= `BHL_SETTING_RST;
        end
        else
        begin
            if (hit(`BHL_MAX_DOD)) max_dod_q <= reg_wdata;
            if (hit(`BHL_AVG_DOD)) avg_dod_q <= reg_wdata;
            if (hit(`BHL_HEALTH_EN)) health_en_q <= reg_wdata;
            if (hit(`BHL_PARAM_RESET)) reset_reg_q <= reg_wdata;
            if (hit(`BHL_CABLE_TEST)) cable_reg_q <= reg_wdata;
        end
    end

    // log control: period, access code, age since newest sample
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            period_q <= `BHL_PERIOD_RST;
            log_ctrl_q <= 16'h0000;
            age_q <= 16'h0000;
        end
        else
        begin
            // out of range period writes are dropped
            if (hit(`BHL_LOG_PERIOD) && period_ok)
                period_q <= reg_wdata;
            // access code kept, samples readable when it matches
            if (hit(`BHL_LOG_CTRL))
                log_ctrl_q <= reg_wdata;
            // age in days, zero on each new sample
            if (period_due)
                age_q <= 16'h0000;
            else if (day_tick && age_q != 16'hFFFF)
                age_q <= age_q + 16'h0001;
        end
    end

    // manual test launch and test kind
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            launch_q <= 16'h0000;
            kind_q <= BHL_TEST_NONE;
        end
        else
        begin
            // finish wins over a fresh launch
            if (manual_done)
                launch_q <= 16'h0000;
            // refused unless the device says a test may start
            else if (hit(`BHL_MAN_LAUNCH) && launch_ok)
                launch_q <= reg_wdata;
            // 0 idle, 1 manual, 2 automatic
            if (launch_q != 16'h0000)
                kind_q <= BHL_TEST_MANUAL;
            else if (auto_busy)
                kind_q <= BHL_TEST_AUTO;
            else
                kind_q <= BHL_TEST_NONE;
        end
    end

    // history counters and lowest voltage seen
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_events_q <= 16'h0000;
            high_events_q <= 16'h0000;
            lowest_volt_q <= 16'hFFFF;
            below_v_q <= 1'b0;
        end
        else
        begin
            below_v_q <= below_v;
            if (hit(`BHL_LOW_V_EVENTS))
                low_events_q <= reg_wdata;
            else if (below_v && !below_v_q && low_events_q != 16'hFFFF)
                low_events_q <= low_events_q + 16'h0001;
            if (hit(`BHL_HIGH_V_EVENTS))
                high_events_q <= reg_wdata;
            else if (high_voltage_event && high_events_q != 16'hFFFF)
                high_events_q <= high_events_q + 16'h0001;
            if (battery_voltage < lowest_volt_q)
                lowest_volt_q <= battery_voltage;
        end
    end

    // alarm words and relay
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_q <= 16'h0000;
            health_q <= 16'h0000;
            alarm_two_q <= 16'h0000;
            alarm_relay <= 1'b0;
        end
        else
        begin
            // sulphated bit only with life test on
            // sense cable bits pass through the mask
            fault_q <= fault_cond & `BHL_FAULT_MASK & ~(16'(!life_test_en) << `BHL_FAULT_SULPH_BIT);
            health_q <= health_cond & `BHL_HEALTH_MASK;
            alarm_two_q <= (16'(nominal_mismatch) << `BHL_NOMV_BIT) | (16'(low_batt) << `BHL_LOWBATT_BIT);
            alarm_relay <= fault_any;
        end
    end

    // command pulses to the measurement logic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            manual_test_start <= 1'b0;
            cable_test_start <= 1'b0;
            param_reset <= 1'b0;
        end
        else
        begin
            manual_test_start <= hit(`BHL_MAN_LAUNCH) && launch_ok && !manual_done;
            cable_test_start <= hit(`BHL_CABLE_TEST);
            param_reset <= hit(`BHL_PARAM_RESET);
        end
    end

    // read selection
    // read-only words ignore writes
    bhl_word_t rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        unique case (reg_addr)
            `BHL_SENSE_VOLT: rd_mux = sense_voltage;
            `BHL_REF_RES: rd_mux = reference_resistance;
            `BHL_DISCH_USED: rd_mux = discharge_used;
            `BHL_EFF_CAP: rd_mux = effective_capacity;
            `BHL_AUTO_HEALTH: rd_mux = auto_health;
            `BHL_TIME_EMPTY: rd_mux = time_to_empty;
            `BHL_PERIODIC_PCT: rd_mux = periodic_percent;
            `BHL_AUTO_RES: rd_mux = measured_internal_resistance;
            `BHL_FAULT_FLAGS: rd_mux = fault_q;
            `BHL_HEALTH_FLAGS: rd_mux = health_q;
            `BHL_ALARM_TWO: rd_mux = alarm_two_q;
            `BHL_CABLE_TEST: rd_mux = cable_reg_q;
            `BHL_LOW_V_EVENTS: rd_mux = low_events_q;
            `BHL_HIGH_V_EVENTS: rd_mux = high_events_q;
            `BHL_MAX_DOD: rd_mux = max_dod_q;
            `BHL_LOWEST_VOLT: rd_mux = lowest_volt_q;
            `BHL_AVG_DOD: rd_mux = avg_dod_q;
            `BHL_PARAM_RESET: rd_mux = reset_reg_q;
            `BHL_HEALTH_EN: rd_mux = health_en_q;
            `BHL_LOW_V_THR: rd_mux = low_v_thr_q;
            `BHL_MAN_LAUNCH: rd_mux = launch_q;
            `BHL_MAN_ALLOWED: rd_mux = 16'(manual_ready);
            `BHL_NOM_RES: rd_mux = nom_res_q;
            `BHL_CABLE_RES: rd_mux = cable_res_q;
            `BHL_CAP_20H: rd_mux = cap20_q;
            `BHL_CAP_10H: rd_mux = cap10_q;
            `BHL_CAP_5H: rd_mux = cap5_q;
            `BHL_CAP_2H: rd_mux = cap2_q;
            `BHL_CAP_1H: rd_mux = cap1_q;
            `BHL_LOW_SOC_THR: rd_mux = low_soc_thr_q;
            `BHL_MAN_RES: rd_mux = manual_resistance;
            `BHL_MAN_HEALTH: rd_mux = manual_health;
            `BHL_TEST_KIND: rd_mux = 16'(kind_q);
            `BHL_LOG_CTRL: rd_mux = log_ctrl_q;
            `BHL_LOG_PERIOD: rd_mux = period_q;
            `BHL_LOG_AGE: rd_mux = age_q;
            // fill level up to the depth
            `BHL_LOG_COUNT: rd_mux = 16'(lg.count);
            // oldest first, zero past the fill or while closed
            default: rd_mux = (in_log && log_open && log_off < 16'(lg.count)) ? lg.rd_data : 16'h0000;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    period_range_a: assert property (hit(`BHL_LOG_PERIOD) && !period_ok |=> $stable(period_q))
        else $error("out of range period stored");
    period_keep_a: assert property (period_q >= `BHL_PERIOD_MIN && period_q <= `BHL_PERIOD_MAX)
        else $error("period outside 7 to 365");
    relay_follow_a: assert property (##1 alarm_relay == $past(fault_any))
        else $error("relay does not follow faults");
    sulph_gate_a: assert property (!life_test_en |=> !fault_q[`BHL_FAULT_SULPH_BIT])
        else $error("sulphated flag without life test");
    low_batt_a: assert property (charging_or_backup && below_v |=> alarm_two_q[`BHL_LOWBATT_BIT])
        else $error("low battery flag missing");
    idle_low_a: assert property (!charging_or_backup |=> !alarm_two_q[`BHL_LOWBATT_BIT])
        else $error("low battery flag while idle");
    launch_clear_a: assert property (manual_done |=> launch_q == 16'h0000 ##1 kind_q != BHL_TEST_MANUAL)
        else $error("launch not cleared at test end");
    launch_refuse_a: assert property (hit(`BHL_MAN_LAUNCH) && !manual_ready && launch_q == 16'h0000 |=> launch_q == 16'h0000)
        else $error("launch taken while not allowed");
    cable_start_a: assert property (hit(`BHL_CABLE_TEST) |=> cable_test_start ##1 !cable_test_start || $past(hit(`BHL_CABLE_TEST)))
        else $error("cable test pulse missing");
    param_reset_a: assert property (hit(`BHL_PARAM_RESET) |=> param_reset && low_soc_thr_q == `BHL_LOW_SOC_RST)
        else $error("battery reset did not restore defaults");
    sample_age_a: assert property (period_due |=> age_q == 16'h0000)
        else $error("age not cleared on new sample");
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
endmodule : bhl_top
